// >>> sfes_top.sv
// serial flash erase and deep-sleep sequencer
// link logic runs on the host serial clock; frames end on the select rising edge,
// which is seen in the system domain through a synchronised select level
// Notes on behaviour
// [RULE1] host issues write-arm before any erase, else the erase is refused
// [RULE2] decoding write-arm sets the write-arm latch
// [RULE3] host keeps select low from first opcode bit to sequence end
// [RULE4] sector erase runs only if select rises right after the 32nd bit
// [RULE5] a valid erase end starts a self-timed erase of the target range
// [RULE6] pending flag reads 1 during the erase cycle and 0 afterwards
// [RULE7] write-arm latch clears before the erase cycle completes
// [RULE8] sector erase on a guarded or boot-locked region is ignored
// [RULE9] half-block erase is 52h with three address bytes, any inside address
// [RULE10] half-block erase runs only if select rises right after the 32nd bit
// [RULE11] half-block erase on a guarded or boot-locked block is ignored
// [RULE12] 64K block erase is d8h with three address bytes, any inside address
// [RULE13] block erase runs only if select rises right after the 32nd bit
// [RULE14] block erase on a guarded or boot-locked block is ignored
// [RULE15] chip erase is c7h or 60h, select rising right after eight bits
// [RULE16] chip erase runs only with all guard bits and the lock bit zero
// [RULE17] deep-sleep is b9h alone, select rising right after eight bits
// [RULE18] deep sleep is entered only after a fixed delay from select rise
// [RULE19] in deep sleep only wake-and-id and software reset are obeyed
// [RULE20] deep-sleep during a running cycle is rejected, cycle untouched
// [RULE21] select high with no cycle running means plain standby
// [RULE22] reset always comes up in standby, never deep sleep
// [RULE23] wake-and-id leaves deep sleep and shifts the one-byte id out
// [RULE24] sector erase is 20h with three address bytes, any inside address
// [RULE25] wake is abh; host then keeps select high for the recovery time
// [RULE26] an erase with the latch clear changes neither memory nor pending flag
module sfes_top #(
  parameter int ERASE_CYC = sfes_pkg::ERASE_CYC_DEF,
  parameter logic [7:0] LEGACY_ID = 8'h5a  // arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_in_line,
  input wire logic [3:0] i_region_guard_bits,
  input wire logic i_global_lock_bit,
  input wire logic i_boot_lock,
  input wire logic i_other_cycle_busy,
  output logic o_serial_out,
  output logic o_serial_out_en,
  output logic o_op_pending_flag,
  output logic o_write_arm_latch,
  output logic o_deep_sleep,
  output logic o_erase_start,
  output sfes_pkg::sfes_erase_t o_erase_req
);
  // link domain: shift register and bit count, cleared while select is high
  typedef struct packed {
    logic [31:0] shift;
    logic [5:0] count;
    logic [7:0] op;
  } sfes_link_t;
  sfes_link_t lk, next_lk;

  always_comb begin
    next_lk = lk;
    if (lk.count != 6'h3f) begin
      next_lk.count = lk.count + 6'h01;
    end
    next_lk.shift = {lk.shift[30:0], i_serial_in_line};
    // opcode kept so the id driver only answers a wake command
    if (lk.count == 6'h07) begin
      next_lk.op = {lk.shift[6:0], i_serial_in_line};
    end
  end

  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // id shifts out on falling edges after the opcode
  logic [2:0] id_idx;
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      id_idx <= 3'h7;
    end else if (lk.count > sfes_pkg::BITS_OPCODE) begin
      id_idx <= id_idx - 3'h1;
    end
  end

  // system domain state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic arm;
    logic busy;
    logic [31:0] timer;
    logic sleep;
    logic sleep_wait;
    logic [15:0] sleep_cnt;
    logic woke_id;
    logic start;
    sfes_pkg::sfes_erase_t req;
  } sfes_state_t;
  sfes_state_t st, next_st;

  // frame captured at select rise; link regs are stable then (cleared only by cs high,
  // so sample a held copy taken on the link side)
  logic [31:0] cap_shift;
  logic [5:0] cap_count;
  always_ff @(posedge i_cs_n) begin
    cap_shift <= lk.shift;
    cap_count <= lk.count;
  end

  logic frame_end;
  logic [7:0] op;
  logic [7:0] op_a;
  logic is_op, is_addr;
  logic guarded, any_guard;
  logic cycle_run;
  assign frame_end = st.cs_s2 & ~st.cs_s3;
  assign op = cap_shift[7:0];
  assign op_a = cap_shift[31:24];
  assign is_op = cap_count == sfes_pkg::BITS_OPCODE;
  assign is_addr = cap_count == sfes_pkg::BITS_ADDR_CMD;
  assign any_guard = (|i_region_guard_bits) | i_global_lock_bit;
  assign guarded = (|i_region_guard_bits) | i_boot_lock;
  assign cycle_run = st.busy | i_other_cycle_busy;

  always_comb begin
    next_st = st;
    next_st.cs_s1 = i_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_s3 = st.cs_s2;
    next_st.start = 1'b0;
    // [RULE6] pending flag timing
    if (st.busy) begin
      if (st.timer == 32'h0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.timer = st.timer - 32'h1;
      end
      // [RULE7] latch clears early
      next_st.arm = 1'b0;
    end
    // [RULE18] delayed sleep entry
    if (st.sleep_wait) begin
      if (st.sleep_cnt == 16'h0) begin
        next_st.sleep_wait = 1'b0;
        next_st.sleep = 1'b1;
      end else begin
        next_st.sleep_cnt = st.sleep_cnt - 16'h1;
      end
    end
    if (frame_end && st.sleep) begin
      // [RULE19] only wake or reset leave sleep
      if (op == sfes_pkg::OP_WAKE_ID || op == sfes_pkg::OP_SW_RESET) begin
        next_st.sleep = 1'b0;
        // [RULE23] wake-and-id exit
        next_st.woke_id = op == sfes_pkg::OP_WAKE_ID;
      end
    end else if (frame_end && !cycle_run && !st.sleep_wait) begin
      // [RULE21] idle frames return to standby
      next_st.woke_id = 1'b0;
      if (is_op && op == sfes_pkg::OP_WRITE_ARM) begin
        // [RULE2] arm latch set
        next_st.arm = 1'b1;
      end else if (is_op && op == sfes_pkg::OP_DEEP_SLEEP) begin
        // [RULE17] exact-length sleep command
        next_st.sleep_wait = 1'b1;
        next_st.sleep_cnt = 16'(sfes_pkg::DSLEEP_CYC - 1);
      end else if (st.arm) begin
        // [RULE1] [RULE26] erase needs the latch
        // [RULE4] [RULE10] [RULE13] [RULE24] exact 32-bit frames
        if (is_addr && op_a == sfes_pkg::OP_FOUR_K && !guarded) begin
          // [RULE8] [RULE5] sector erase
          next_st.req = '{kind: sfes_pkg::ERASE_4K, addr: {cap_shift[23:12], 12'h000}};
          next_st.start = 1'b1;
        end else if (is_addr && op_a == sfes_pkg::OP_HALF_BLK && !guarded) begin
          // [RULE9] [RULE11] half block
          next_st.req = '{kind: sfes_pkg::ERASE_32K, addr: {cap_shift[23:15], 15'h0000}};
          next_st.start = 1'b1;
        end else if (is_addr && op_a == sfes_pkg::OP_FULL_BLK && !guarded) begin
          // [RULE12] [RULE14] full block
          next_st.req = '{kind: sfes_pkg::ERASE_64K, addr: {cap_shift[23:16], 16'h0000}};
          next_st.start = 1'b1;
        end else if (is_op && (op == sfes_pkg::OP_CHIP_A || op == sfes_pkg::OP_CHIP_B) && !any_guard) begin
          // [RULE15] [RULE16] chip erase
          next_st.req = '{kind: sfes_pkg::ERASE_CHIP, addr: 24'h000000};
          next_st.start = 1'b1;
        end
      end
    end
    // [RULE20] sleep rejected while a cycle runs: falls through above
    if (next_st.start) begin
      next_st.busy = 1'b1;
      next_st.timer = 32'(ERASE_CYC - 1);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      // [RULE22] standby after reset
      st <= '0;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_s3 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // [RULE23] id output while selected with a wake command
  assign o_serial_out_en = ~i_cs_n & (lk.count > sfes_pkg::BITS_OPCODE) & (lk.op == sfes_pkg::OP_WAKE_ID) & ~cycle_run;
  assign o_serial_out = LEGACY_ID[id_idx];
  assign o_op_pending_flag = st.busy;
  assign o_write_arm_latch = st.arm;
  assign o_deep_sleep = st.sleep;
  assign o_erase_start = st.start;
  assign o_erase_req = st.req;

  a_busy_after_start: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.start |-> st.busy ##1 st.busy) else $error("pending flag not set by erase start"); // [RULE6]
  a_arm_clears: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.busy |=> !st.arm) else $error("write-arm latch stays during erase"); // [RULE7]
  a_start_needs_arm: assert property (@(posedge i_mclk) disable iff (i_rst)
    next_st.start |-> st.arm) else $error("erase started without latch"); // [RULE1]
  a_chip_guard: assert property (@(posedge i_mclk) disable iff (i_rst)
    (next_st.start && next_st.req.kind == sfes_pkg::ERASE_CHIP) |-> !any_guard) else $error("chip erase while guarded"); // [RULE16]
  a_region_guard: assert property (@(posedge i_mclk) disable iff (i_rst)
    (next_st.start && next_st.req.kind != sfes_pkg::ERASE_CHIP) |-> !guarded) else $error("guarded region erased"); // [RULE8]
  a_sleep_delay: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(st.sleep_wait) |-> !st.sleep [*8]) else $error("sleep entered too early"); // [RULE18]
  a_no_start_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.busy && st.timer != 32'h0 |=> !st.start) else $error("erase started over running cycle"); // [RULE20]
  a_sleep_blocks: assert property (@(posedge i_mclk) disable iff (i_rst)
    st.sleep |-> !next_st.start) else $error("erase obeyed in deep sleep"); // [RULE19]
endmodule

// >>> sfes_pkg.sv
// package for the serial flash erase and deep-sleep sequencer
// assumes a 40 MHz system clock and an spi serial clock from the host
package sfes_pkg;
  localparam logic [7:0] OP_WRITE_ARM = 8'h06;
  localparam logic [7:0] OP_FOUR_K = 8'h20;
  localparam logic [7:0] OP_HALF_BLK = 8'h52;
  localparam logic [7:0] OP_FULL_BLK = 8'hd8;
  localparam logic [7:0] OP_CHIP_A = 8'hc7;
  localparam logic [7:0] OP_CHIP_B = 8'h60;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_SW_RESET = 8'h99;
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
  // deep-sleep entry delay after the select edge
  localparam int T_DSLEEP_NS = 3000;
  localparam int CLK_NS = 25;
  localparam int DSLEEP_CYC = (T_DSLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC_DEF = 4000;
  typedef enum logic [2:0] {ERASE_NONE, ERASE_4K, ERASE_32K, ERASE_64K, ERASE_CHIP} sfes_kind_t;
  typedef struct packed {
    sfes_kind_t kind;
    logic [23:0] addr;
  } sfes_erase_t;
endpackage

// >>> sfes_host.sv
// host-side serial controller model: select, serial clock, data out
// assumes the bench calls xfer only between frames
module sfes_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // select held low over the whole frame
  task automatic xfer(input logic [39:0] v, input int n, output logic [7:0] rx);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi = v[i];
      #32 o_sclk = 1'b1;
      rx = {rx[6:0], i_miso};
      #32 o_sclk = 1'b0;
    end
    o_mosi = ~o_mosi;
    #32 o_cs_n = 1'b1;
    #200;
  endtask
endmodule

// >>> tb_sfes_top.sv
// self-checking bench for sfes_top erase and deep-sleep paths
// assumes sfes_host drives the serial side; erase cycle is shortened
module tb_sfes_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ECYC = 200;
  localparam logic [7:0] ID = 8'h3c;  // arbitrary value
  logic mclk, rst, sclk, cs_n, sdi, sdo, sdo_en, pend, latch, sleep, start, lock, boot, obusy;
  logic [3:0] guard;
  logic [7:0] rx;
  sfes_pkg::sfes_erase_t req, last_req;
  int n_errors = 0, samples_checked = 0, starts = 0, cyc = 0;
  sfes_top #(.ERASE_CYC(ECYC), .LEGACY_ID(ID)) i_dut (.i_mclk(mclk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_in_line(sdi), .i_region_guard_bits(guard), .i_global_lock_bit(lock), .i_boot_lock(boot),
    .i_other_cycle_busy(obusy), .o_serial_out(sdo), .o_serial_out_en(sdo_en), .o_op_pending_flag(pend),
    .o_write_arm_latch(latch), .o_deep_sleep(sleep), .o_erase_start(start), .o_erase_req(req));
  // a released output line reads as the inverse of the driven bit
  sfes_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(sdi), .i_miso(sdo_en ? sdo : ~sdo));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    cyc++;
    if (start === 1'b1) begin
      starts++;
      last_req = req;
    end
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [39:0] v, input int n, input int w);
    u_host.xfer(v, n, rx);
    repeat (w) @(negedge mclk);
  endtask
  task automatic t_erase(input logic [7:0] op, input int n, input sfes_pkg::sfes_kind_t k, input logic [23:0] m);
    int s0;
    s0 = starts;
    cmd(40'h06, 8, 8);
    chk("latch", 32'h1, 32'(latch));
    cmd((n == 8) ? {32'h0, op} : {8'h0, op, 24'h5a7b3c}, n, 8);
    chk("starts", 32'(s0 + 1), 32'(starts));
    chk("kind", 32'(k), 32'(last_req.kind));
    chk("addr", 32'(24'h5a7b3c & m), 32'(last_req.addr));
    chk("pend", 32'h1, 32'(pend));
    cmd(40'hb9, 8, 130);
    chk("sleep", 32'h0, 32'(sleep));
    chk("pend", 32'h1, 32'(pend));
    repeat (ECYC) @(negedge mclk);
    chk("pend", 32'h0, 32'(pend));
    chk("latch", 32'h0, 32'(latch));
    $display("erase %h done", op);
  endtask
  task automatic nogo(input logic [39:0] v, input int n, input logic arm);
    int s0;
    s0 = starts;
    if (arm) begin
      cmd(40'h06, 8, 8);
    end
    cmd(v, n, 8);
    chk("starts", 32'(s0), 32'(starts));
    chk("pend", 32'h0, 32'(pend));
  endtask
  task automatic t_refuse();
    nogo(40'h205a7b3c, 32, 1'b0);
    nogo(40'h102d3d9e, 31, 1'b1);
    nogo(40'h525a7b, 24, 1'b1);
    nogo(40'h1b0b4f678, 33, 1'b1);
    nogo(40'h18e, 9, 1'b1);
    guard = 4'hf;
    nogo(40'h205a7b3c, 32, 1'b1);
    nogo(40'h525a7b3c, 32, 1'b1);
    guard = 4'h0;
    boot = 1'b1;
    nogo(40'hd85a7b3c, 32, 1'b1);
    boot = 1'b0;
    lock = 1'b1;
    nogo(40'hc7, 8, 1'b1);
    lock = 1'b0;
    $display("refusals done");
  endtask
  task automatic t_sleep();
    cmd(40'hb9, 8, 60);
    chk("sleep", 32'h0, 32'(sleep));
    repeat (70) @(negedge mclk);
    chk("sleep", 32'h1, 32'(sleep));
    cmd(40'h06, 8, 8);
    chk("latch", 32'h0, 32'(latch));
    cmd(40'hab, 8, 48);
    chk("sleep", 32'h0, 32'(sleep));
    cmd(40'hab00000000, 40, 8);
    chk("id", 32'(ID), 32'(rx));
    cmd(40'hb9, 8, 130);
    cmd(40'h99, 8, 8);
    chk("sleep", 32'h0, 32'(sleep));
    obusy = 1'b1;
    cmd(40'hb9, 8, 130);
    chk("sleep", 32'h0, 32'(sleep));
    obusy = 1'b0;
    cmd(40'hb9, 8, 130);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    chk("sleep", 32'h0, 32'(sleep));
    $display("sleep done");
  endtask
  initial begin
    rst = 1'b1;
    {guard, lock, boot, obusy} = '0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("sleep", 32'h0, 32'(sleep));
    t_refuse();
    t_erase(8'h20, 32, sfes_pkg::ERASE_4K, 24'hfff000);
    t_erase(8'h52, 32, sfes_pkg::ERASE_32K, 24'hff8000);
    t_erase(8'hd8, 32, sfes_pkg::ERASE_64K, 24'hff0000);
    t_erase(8'hc7, 8, sfes_pkg::ERASE_CHIP, 24'h0);
    t_erase(8'h60, 8, sfes_pkg::ERASE_CHIP, 24'h0);
    t_sleep();
    results();
  end
endmodule
